// ### verilog/rra_regs.svh
// Constants for the remote read arbiter: field widths, codes, timing.
// Assumes inclusion by bare name from design files.
`ifndef RRA_REGS_SVH
`define RRA_REGS_SVH
`define RRA_MS_DATA_MEMORY 2'h0
`define RRA_MS_INSTRUCTION_MEMORY 2'h1
`define RRA_MS_PCLO 2'h2
`define RRA_MS_PCHI 2'h3
`define RRA_IW_W 2
`define RRA_DW_W 3
`define RRA_TSTATE_NS 8
`define RRA_CLK_NS 8
`define RRA_HIB_RST 1'b0
`endif

// ### verilog/rra_pkg.sv
// Types shared by the remote read arbiter modules.
// Assumes no other package.
package rra_pkg;
  typedef enum logic [1:0] {
    RRA_SRC_RIC = 2'h0,
    RRA_SRC_PC = 2'h1,
    RRA_SRC_INSTRUCTION_MEMORY = 2'h2,
    RRA_SRC_DATA_MEMORY = 2'h3
  } rra_src_e;
endpackage

// ### verilog/rra_wait_if.sv
// Interface between the arbiter state machine and its wait-state counter.
// Assumes one clock domain.
`include "rra_regs.svh"
`timescale 1ns/1ps
`default_nettype none
interface rra_wait_if;
  logic load;
  logic sel_instruction_memory;
  logic [`RRA_IW_W-1:0] iw;
  logic [`RRA_DW_W-1:0] dw;
  logic done;
  modport fsm (output load, output sel_instruction_memory, output iw, output dw,
    input done);
  modport cnt (input load, input sel_instruction_memory, input iw, input dw,
    output done);
endinterface
`default_nettype wire

// ### verilog/rra_wait_cnt.sv
// Programmed wait-state counters for instruction and data memory.
// Assumes load pulses in the bus-take-complete state, one count per clock.
`include "rra_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module rra_wait_cnt (
  input wire logic mclk,
  input wire logic rstn,
  rra_wait_if.cnt wif
);
  logic [`RRA_IW_W-1:0] iw_ff;
  logic [`RRA_DW_W-1:0] dw_ff;

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      iw_ff <= '0;
    end else if (wif.load) begin
      iw_ff <= wif.iw; // R18
    end else if (iw_ff != '0 && wif.sel_instruction_memory) begin
      iw_ff <= iw_ff - 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      dw_ff <= '0;
    end else if (wif.load) begin
      dw_ff <= wif.dw; // R18
    end else if (dw_ff != '0 && !wif.sel_instruction_memory) begin
      dw_ff <= dw_ff - 1'b1;
    end
  end

  assign wif.done = wif.sel_instruction_memory ? (iw_ff == '0) : (dw_ff == '0);
endmodule
`default_nettype wire

// ### verilog/rra_arbiter.sv
// Remote read arbitration state machine: buffered and latched read modes.
// Assumes remote pins are pre-synchronised by two flops here; one clock.
// Operation
// [R1] State changes on clock edge only; conditional outputs act combinationally.
// [R2] Remote side may extend access by holding wait input low.
// [R3] Access state moves to end state once waits expire and wait high.
// [R4] Buffered end state repeats until enable and read strobe removed.
// [R5] Entering end state raises acknowledge, starting termination.
// [R6] Non-data end states drop owner output once strobe is removed.
// [R7] First final state: owner low, address floats first half only.
// [R8] Second final state keeps owner high, both buses floating.
// [R9] First final returns to idle; toggles byte flag, bumps counter.
// [R10] Second final goes to recovery: owner low, buses float half state.
// [R11] Taking bus from a local read waits one T-state first.
// [R12] Address settles one T-state before read strobe; then data waits.
// [R13] Remote removes strobe after acknowledge; device waits before return.
// [R14] Latched mode terminates once data valid, not on strobe trailing edge.
// [R15] Hold in waiting arbitration while locked out or bus granted locally.
// [R16] Acknowledge goes low as soon as enable and strobe both active.
// [R17] Free bus: enter bus-take next clock, refuse local grants, float buses.
// [R18] After bus take: owner high, acknowledge low, load wait counters.
// [R19] Command and select field pick control reg, counter bytes or data.
// [R20] Instruction select outputs low or high byte per flag with waits.
// [R21] Byte flag clears on reset and on writing instruction select.
// [R22] Latched end state raises acknowledge, holds strobe half a state.
// [R23] Latched final: owner low, grants resume, then wait strobe removal.
`include "rra_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module rra_arbiter #(
  parameter int PC_W = 16
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic remote_access_enable,
  input wire logic remote_read_strobe_n,
  input wire logic remote_wait_n,
  input wire logic remote_cmd,
  input wire logic latched_mode,
  input wire logic lock_out_remote,
  input wire logic lock_in,
  input wire logic local_bus_request,
  input wire logic local_read_active,
  input wire logic [1:0] memory_select_field,
  input wire logic memory_select_wr,
  input wire logic [`RRA_IW_W-1:0] instr_wait_field,
  input wire logic [`RRA_DW_W-1:0] data_wait_field,
  input wire logic [7:0] interface_control_reg,
  input wire logic [15:0] instr_word,
  input wire logic [PC_W-1:0] pc_value,
  output logic local_bus_grant,
  output logic local_bus_owner_n,
  output logic transfer_acknowledge,
  output logic mem_read_n,
  output logic addr_oe,
  output logic ad_oe,
  output logic [7:0] ad_out,
  output logic pc_increment,
  output logic high_byte_flag,
  output logic remote_stall_state
);
  typedef enum logic [12:0] {
    ST_A1 = 13'h0001, ST_A2 = 13'h0002, ST_A3 = 13'h0004,
    ST_B = 13'h0008, ST_C = 13'h0010, ST_D = 13'h0020,
    ST_E = 13'h0040, ST_F1 = 13'h0080, ST_F2 = 13'h0100,
    ST_LF = 13'h0200, ST_G = 13'h0400, ST_BH = 13'h0800,
    ST_DW = 13'h1000
  } rra_state_e;

  rra_state_e state_ff;
  rra_state_e nxt_state;
  rra_pkg::rra_src_e src_ff;
  rra_pkg::rra_src_e nxt_src;
  logic [1:0] rae_sync_ff;
  logic [1:0] rd_sync_ff;
  logic [1:0] wait_sync_ff;
  logic req;
  logic req_raw;
  logic pc_hi_ff;
  logic hib_ff;
  logic grant_ff;
  logic [7:0] ad_ff;
  logic cyc_ms_instruction_memory_hi;
  rra_wait_if wif ();

  // Two-flop synchronisers; only the second stage is read
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      rae_sync_ff <= 2'h0;
      rd_sync_ff <= 2'h3;
      wait_sync_ff <= 2'h3;
    end else begin
      rae_sync_ff <= {rae_sync_ff[0], remote_access_enable};
      rd_sync_ff <= {rd_sync_ff[0], remote_read_strobe_n};
      wait_sync_ff <= {wait_sync_ff[0], remote_wait_n};
    end
  end

  assign req = rae_sync_ff[1] & ~rd_sync_ff[1];
  assign req_raw = req;

  function automatic rra_pkg::rra_src_e pick_src(input logic cmd,
    input logic [1:0] ms);
    if (cmd) begin
      pick_src = rra_pkg::RRA_SRC_RIC;
    end else if (ms == `RRA_MS_DATA_MEMORY) begin
      pick_src = rra_pkg::RRA_SRC_DATA_MEMORY;
    end else if (ms == `RRA_MS_INSTRUCTION_MEMORY) begin
      pick_src = rra_pkg::RRA_SRC_INSTRUCTION_MEMORY;
    end else begin
      pick_src = rra_pkg::RRA_SRC_PC;
    end
  endfunction

  assign wif.load = (state_ff == ST_C); // R18
  assign wif.sel_instruction_memory = (src_ff == rra_pkg::RRA_SRC_INSTRUCTION_MEMORY);
  assign wif.iw = instr_wait_field;
  assign wif.dw = data_wait_field;

  rra_wait_cnt u_wait (
    .mclk(mclk),
    .rstn(rstn),
    .wif(wif)
  );

  always_comb begin
    nxt_state = state_ff;
    nxt_src = src_ff;
    case (state_ff)
      ST_A1, ST_A3: begin
        if (req && (lock_out_remote || local_bus_request)) begin
          nxt_state = ST_A2; // R15
        end else if (req && local_read_active) begin
          nxt_state = ST_BH; // R11
        end else if (req) begin
          nxt_state = ST_B; // R17
        end else begin
          nxt_state = ST_A1;
        end
      end
      ST_A2: begin
        if (!req) begin
          nxt_state = ST_A1;
        end else if (!(lock_out_remote || local_bus_request)) begin
          nxt_state = local_read_active ? ST_BH : ST_B; // R15
        end
      end
      ST_BH: nxt_state = ST_B; // R11
      ST_B: begin
        nxt_state = ST_C;
        nxt_src = pick_src(remote_cmd, memory_select_field); // R19
      end
      ST_C: nxt_state = ST_D; // R12
      ST_D: begin
        // Control register and counter bytes carry no programmed waits
        if ((wif.done || !(src_ff == rra_pkg::RRA_SRC_DATA_MEMORY ||
            src_ff == rra_pkg::RRA_SRC_INSTRUCTION_MEMORY)) && wait_sync_ff[1]) begin
          nxt_state = ST_E; // R3
        end
      end
      ST_E: begin
        if (latched_mode) begin
          nxt_state = ST_LF; // R14
        end else if (!req) begin
          nxt_state = (src_ff == rra_pkg::RRA_SRC_DATA_MEMORY) ? ST_F2 : ST_F1;
        end
      end
      ST_F1: nxt_state = ST_A1; // R9
      ST_F2: nxt_state = ST_A3; // R10
      ST_LF: nxt_state = req ? ST_G : ST_A1; // R23
      ST_G: nxt_state = req ? ST_G : ST_A1; // R23
      ST_DW: nxt_state = ST_A1;
      default: nxt_state = ST_A1;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      state_ff <= ST_A1;
      src_ff <= rra_pkg::RRA_SRC_RIC;
    end else begin
      state_ff <= nxt_state; // R1
      src_ff <= nxt_src;
    end
  end

  // Instruction byte flag and counter bump at end of an INSTRUCTION_MEMORY read
  assign cyc_ms_instruction_memory_hi = (src_ff == rra_pkg::RRA_SRC_INSTRUCTION_MEMORY) && hib_ff;
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      hib_ff <= `RRA_HIB_RST; // R21
    end else if ((state_ff == ST_F1 || state_ff == ST_LF) &&
                 src_ff == rra_pkg::RRA_SRC_INSTRUCTION_MEMORY) begin
      hib_ff <= ~hib_ff; // R9
    end else if (memory_select_wr &&
                 memory_select_field == `RRA_MS_INSTRUCTION_MEMORY) begin
      hib_ff <= 1'b0; // R21
    end
  end
  assign pc_increment = (state_ff == ST_F1 || state_ff == ST_LF) &&
                        cyc_ms_instruction_memory_hi; // R9
  assign high_byte_flag = hib_ff;

  // Read data mux, registered
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      ad_ff <= 8'h00;
      pc_hi_ff <= 1'b0;
    end else begin
      pc_hi_ff <= (memory_select_field == `RRA_MS_PCHI);
      case (src_ff)
        rra_pkg::RRA_SRC_PC: ad_ff <= pc_hi_ff ?
          pc_value[PC_W-1 -: 8] : pc_value[7:0]; // R19
        rra_pkg::RRA_SRC_INSTRUCTION_MEMORY: ad_ff <= hib_ff ?
          instr_word[15:8] : instr_word[7:0]; // R20
        default: ad_ff <= interface_control_reg;
      endcase
    end
  end
  assign ad_out = ad_ff;

  // Arbitration states: the local side may still own the bus
  function automatic logic in_arb(input rra_state_e s);
    in_arb = (s == ST_A1) || (s == ST_A2) || (s == ST_A3);
  endfunction

  // Local grant: only in arbitration states or ST_G with lock high
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      grant_ff <= 1'b0;
    end else begin
      grant_ff <= local_bus_request && lock_in &&
        (in_arb(nxt_state) || nxt_state == ST_G); // R15 R17 R23
    end
  end
  assign local_bus_grant = grant_ff;
  assign remote_stall_state = local_bus_request && !grant_ff &&
    !in_arb(state_ff); // R11

  // Owner output; buffered non-data end state drops once strobe gone
  always_comb begin
    case (state_ff)
      ST_C, ST_D, ST_F2: local_bus_owner_n = 1'b1; // R8 R18
      ST_E: local_bus_owner_n = latched_mode ||
        (src_ff == rra_pkg::RRA_SRC_DATA_MEMORY) || req_raw; // R4 R6
      default: local_bus_owner_n = 1'b0; // R7 R10 R23
    endcase
  end

  // Acknowledge low from request until end state
  always_comb begin
    case (state_ff)
      ST_E, ST_F1, ST_F2, ST_LF, ST_G: transfer_acknowledge = 1'b1; // R5 R22
      ST_B, ST_BH, ST_C, ST_D: transfer_acknowledge = 1'b0; // R18
      default: transfer_acknowledge = !req; // R16
    endcase
  end

  // Read strobe: data access state, buffered end state while requested, half-state hold in latched end
  always_comb begin
    mem_read_n = 1'b1;
    if (src_ff == rra_pkg::RRA_SRC_DATA_MEMORY) begin
      if (state_ff == ST_D) begin
        mem_read_n = 1'b0; // R12 R19
      end else if (state_ff == ST_E && latched_mode && mclk) begin
        mem_read_n = 1'b0; // R22
      end else if (state_ff == ST_E && !latched_mode && req) begin
        mem_read_n = 1'b0; // R13
      end
    end
  end

  // Bus float; half-state phases use the clock's high level
  always_comb begin
    addr_oe = 1'b1;
    ad_oe = 1'b1;
    case (state_ff)
      ST_B: begin
        addr_oe = mclk; // R17
        ad_oe = mclk || (pick_src(remote_cmd, memory_select_field) !=
          rra_pkg::RRA_SRC_DATA_MEMORY); // R17
      end
      ST_C, ST_D, ST_E, ST_F2: begin
        addr_oe = 1'b0; // R4 R8
        ad_oe = src_ff != rra_pkg::RRA_SRC_DATA_MEMORY; // R4
      end
      ST_F1: addr_oe = !mclk; // R7
      ST_A3: begin
        addr_oe = !mclk; // R10
        ad_oe = !mclk;
      end
      ST_LF: begin
        addr_oe = !mclk; // R23
        ad_oe = (src_ff != rra_pkg::RRA_SRC_DATA_MEMORY) || !mclk;
      end
      default: begin
        addr_oe = 1'b1;
        ad_oe = 1'b1;
      end
    endcase
  end
endmodule
`default_nettype wire

// ### tb/rra_arbiter_properties.sv
// Concurrent checks on the remote read arbiter's ports.
// Assumes binding to rra_arbiter; one clock, synchronous reset.
`timescale 1ns/1ps
`default_nettype none
module rra_arbiter_props (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic remote_read_strobe_n,
  input wire logic latched_mode,
  input wire logic [1:0] memory_select_field,
  input wire logic memory_select_wr,
  input wire logic local_bus_request,
  input wire logic local_bus_grant,
  input wire logic local_bus_owner_n,
  input wire logic transfer_acknowledge,
  input wire logic mem_read_n,
  input wire logic addr_oe,
  input wire logic ad_oe,
  input wire logic pc_increment,
  input wire logic high_byte_flag,
  input wire logic remote_stall_state
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  a_grant_refused: assert property (local_bus_owner_n |-> !local_bus_grant)
    else $error("local grant while remote owns the bus");
  a_stall_no_grant: assert property (local_bus_request &&
    local_bus_owner_n |-> remote_stall_state)
    else $error("local request not stalled while remote owns");
  a_read_floats: assert property (!mem_read_n |-> !addr_oe && !ad_oe)
    else $error("bus driven during remote read");
  a_read_owned: assert property (!latched_mode && !mem_read_n |->
    local_bus_owner_n)
    else $error("read strobe without remote ownership");
  a_owner_floats: assert property (local_bus_owner_n |-> !addr_oe)
    else $error("address driven while remote owns");
  a_ack_rise_owned: assert property (!latched_mode &&
    $rose(transfer_acknowledge) |-> local_bus_owner_n)
    else $error("acknowledge rose outside end state");
  a_owner_after_ack: assert property (!latched_mode &&
    $fell(local_bus_owner_n) |-> transfer_acknowledge)
    else $error("ownership returned before acknowledge");
  a_end_repeats: assert property (!latched_mode && local_bus_owner_n &&
    transfer_acknowledge && !remote_read_strobe_n |=> local_bus_owner_n)
    else $error("end state left while strobe held");
  a_pc_hib: assert property (pc_increment |=> !high_byte_flag)
    else $error("byte flag not toggled on increment");
  a_hib_clear: assert property (memory_select_wr &&
    memory_select_field == 2'h1 |=> !high_byte_flag)
    else $error("byte flag not cleared by select write");
endmodule
`default_nettype wire

// ### tb/rra_host_model.sv
// Remote processor: one read per go pulse, reports data on done.
// Assumes acknowledge high means read data is valid.
`timescale 1ns/1ps
`default_nettype none
module rra_host_model (
  input wire logic mclk,
  input wire logic go,
  input wire logic [3:0] nwait,
  input wire logic transfer_acknowledge,
  input wire logic ad_oe,
  input wire logic [7:0] ad_out,
  output logic remote_access_enable,
  output logic remote_read_strobe_n,
  output logic remote_wait_n,
  output logic done,
  output logic [8:0] data
);
  int n;
  logic seen;
  initial begin
    remote_access_enable = 0;
    remote_read_strobe_n = 1;
    remote_wait_n = 1;
    done = 0;
    data = 9'h000;
    forever begin
      @(posedge mclk);
      done <= 0;
      if (go) begin
        remote_access_enable <= 1;
        remote_read_strobe_n <= 0;
        remote_wait_n <= (nwait == 4'h0);
        seen = 0;
        for (n = 0; n < 300 && !(seen && transfer_acknowledge); n++) begin
          @(posedge mclk);
          if (!transfer_acknowledge) seen = 1;
          if (n >= nwait) remote_wait_n <= 1;
        end
        // Data is reported as floating when the device does not drive it
        data <= ad_oe ? {1'b1, ad_out} : 9'h000;
        remote_access_enable <= 0;
        remote_read_strobe_n <= 1;
        remote_wait_n <= 1;
        done <= 1;
      end
    end
  end
endmodule
`default_nettype wire

// ### tb/remote_read_arbiter_tb.sv
// Self-checking bench for the remote read arbiter.
// Assumes host model and property checker are compiled before it.
`timescale 1ns/1ps
`default_nettype none
module remote_read_arbiter_tb;
  logic mclk, rstn, remote_access_enable, remote_read_strobe_n, remote_wait_n;
  logic remote_cmd, latched_mode, lock_out_remote, lock_in, local_bus_request;
  logic local_read_active, memory_select_wr, go, done;
  logic [1:0] memory_select_field, instr_wait_field;
  logic [2:0] data_wait_field;
  logic [7:0] interface_control_reg, ad_out;
  logic [15:0] instr_word, pc_value;
  logic local_bus_grant, local_bus_owner_n, transfer_acknowledge, mem_read_n;
  logic addr_oe, ad_oe, pc_increment, high_byte_flag, remote_stall_state;
  logic [3:0] nwait;
  logic [8:0] data;
  logic [8:0] exq[$];
  int seed = 49;
  int compares, miscompares, npc, m;
  rra_arbiter rra_arbiter_i (.mclk, .rstn, .remote_access_enable,
    .remote_read_strobe_n, .remote_wait_n, .remote_cmd, .latched_mode,
    .lock_out_remote, .lock_in, .local_bus_request, .local_read_active,
    .memory_select_field, .memory_select_wr, .instr_wait_field,
    .data_wait_field, .interface_control_reg, .instr_word, .pc_value,
    .local_bus_grant, .local_bus_owner_n, .transfer_acknowledge, .mem_read_n,
    .addr_oe, .ad_oe, .ad_out, .pc_increment, .high_byte_flag,
    .remote_stall_state);
  rra_host_model rra_host_model_i (.mclk, .go, .nwait, .transfer_acknowledge,
    .ad_oe, .ad_out, .remote_access_enable, .remote_read_strobe_n,
    .remote_wait_n, .done, .data);
  initial begin
    mclk = 0;
    forever #4 mclk = ~mclk;
  end
  task automatic conclude();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic check(input logic [8:0] s, input logic [8:0] e);
    compares++;
    if (s !== e) begin
      miscompares++;
      $display("unexpected at %0t: saw %h want %h", $time, s, e);
    end
  endtask
  task automatic rd(input logic c, input logic [1:0] ms, input logic [8:0] e);
    int k;
    @(posedge mclk);
    remote_cmd <= c;
    memory_select_field <= ms;
    nwait <= 4'($random(seed) & 7);
    local_read_active <= 1'($random(seed));
    exq.push_back(e);
    @(posedge mclk);
    go <= 1;
    @(posedge mclk);
    go <= 0;
    for (k = 0; k < 400 && done !== 1'b1; k++) @(posedge mclk);
    if (k == 400) begin
      miscompares++;
      conclude();
    end else begin
      repeat (4) @(posedge mclk);
    end
  endtask
  always @(posedge mclk) begin
    if (pc_increment === 1'b1) npc++;
    if (done === 1'b1) check(data, exq.pop_front());
  end
  initial begin
    rstn = 0;
    go = 0;
    nwait = 4'h0;
    remote_cmd = 0;
    latched_mode = 0;
    lock_out_remote = 0;
    lock_in = 1;
    local_bus_request = 0;
    local_read_active = 0;
    memory_select_wr = 0;
    memory_select_field = 2'h0;
    instr_wait_field = 2'($random(seed));
    data_wait_field = 3'($random(seed));
    interface_control_reg = 8'($random(seed));
    instr_word = 16'($random(seed));
    pc_value = 16'($random(seed));
    repeat (3) @(posedge mclk);
    rstn <= 1;
    @(posedge mclk);
    check({8'h00, high_byte_flag}, 9'h000);
    for (m = 0; m < 2; m++) begin
      latched_mode <= 1'(m);
      rd(1, 2'h0, {1'b1, interface_control_reg});
      rd(0, 2'h2, {1'b1, pc_value[7:0]});
      rd(0, 2'h3, {1'b1, pc_value[15:8]});
      rd(0, 2'h0, 9'h000);
      rd(0, 2'h1, {1'b1, instr_word[7:0]});
      rd(0, 2'h1, {1'b1, instr_word[15:8]});
    end
    check(9'(npc), 9'h002);
    rd(0, 2'h1, {1'b1, instr_word[7:0]});
    @(posedge mclk);
    memory_select_wr <= 1;
    @(posedge mclk);
    memory_select_wr <= 0;
    rd(0, 2'h1, {1'b1, instr_word[7:0]});
    latched_mode <= 0;
    lock_out_remote <= 1;
    local_bus_request <= 1;
    fork
      rd(1, 2'h0, {1'b1, interface_control_reg});
      begin
        repeat (20) @(posedge mclk);
        check({8'h00, transfer_acknowledge}, 9'h000);
        check({8'h00, local_bus_grant}, 9'h001);
        lock_out_remote <= 0;
        local_bus_request <= 0;
        repeat (2) @(posedge mclk);
        local_bus_request <= 1;
        repeat (2) @(posedge mclk);
        check({8'h00, remote_stall_state}, 9'h001);
        check({8'h00, local_bus_grant}, 9'h000);
      end
    join
    conclude();
  end
endmodule
bind rra_arbiter rra_arbiter_props rra_arbiter_props_i (.mclk, .rstn,
  .remote_read_strobe_n, .latched_mode, .memory_select_field,
  .memory_select_wr, .local_bus_request, .local_bus_grant, .local_bus_owner_n,
  .transfer_acknowledge, .mem_read_n, .addr_oe, .ad_oe, .pc_increment,
  .high_byte_flag, .remote_stall_state);
`default_nettype wire
